// [rtl/psrc_top.sv]
/*
  Peripheral soft reset controller: two APB registers whose bits hold
  on-chip peripherals in reset. Writes are masked by capability inputs.
  Assumes APB3 master on SYS_CLK and capability masks that are static or
  change only from the same clock domain.
*/
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps

// Function
// RL1 - Register A writes masked by capability A
// RL2 - Register B writes masked by capability B
// RL3 - Both registers reset to all zeros
// RL4 - Bit 24 of A resets CAN zero
// RL5 - Bit 16 of A resets converter zero
// RL6 - Bit 6 of A resets hibernation unit
// RL7 - Bit 3 of A resets watchdog
// RL8 - B bits 26..24 reset comparators two..zero
// RL9 - B bits 19..16 reset timers three..zero
// RL10 - Bit 12 of B resets two-wire bus
// RL11 - Bit 4 of B resets sync serial
// RL12 - B bits 1,0 reset async serial one,zero
// RL13 - Unassigned bits read-only, read zero
// RL14 - Bit high holds peripheral in reset
// RL15 - Absent unit bit ignores writes, stays zero; code keeps a bit set before capability cleared
module psrc_top (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [31:0] CAPABILITY_MASK_A,
  input  wire logic [31:0] CAPABILITY_MASK_B,
  output logic             CAN_CTRL_ZERO_RESET,
  output logic             CONV_ZERO_RESET,
  output logic             HIBERNATION_UNIT_RESET,
  output logic             WATCHDOG_UNIT_RESET,
  output logic             COMPARATOR_ZERO_RESET,
  output logic             COMPARATOR_ONE_RESET,
  output logic             COMPARATOR_TWO_RESET,
  output logic             GP_TIMER_ZERO_RESET,
  output logic             GP_TIMER_ONE_RESET,
  output logic             GP_TIMER_TWO_RESET,
  output logic             GP_TIMER_THREE_RESET,
  output logic             TWO_WIRE_BUS_ZERO_RESET,
  output logic             SYNC_SERIAL_ZERO_RESET,
  output logic             ASYNC_SERIAL_ZERO_RESET,
  output logic             ASYNC_SERIAL_ONE_RESET
);

  // -----------------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------------
  logic        acc;
  logic        hit_a;
  logic        hit_b;
  logic [31:0] soft_reset_a_ff;
  logic [31:0] soft_reset_b_ff;
  logic [31:0] nxt_soft_reset_a;
  logic [31:0] nxt_soft_reset_b;
  logic [31:0] wmask_a;
  logic [31:0] wmask_b;

  assign acc   = PSEL && PENABLE;
  assign hit_a = (PADDR == psrc_pkg::OFS_SOFT_RESET_A);
  assign hit_b = (PADDR == psrc_pkg::OFS_SOFT_RESET_B);

  // Zero wait states; an unmapped address answers with an error.
  assign PREADY  = 1'b1;
  assign PSLVERR = acc && !(hit_a || hit_b);

  // -----------------------------------------------------------------------
  // Register write path
  // -----------------------------------------------------------------------
  // Only bits that exist in the map and whose unit is present may change.
  assign wmask_a = psrc_pkg::IMPL_MASK_A & CAPABILITY_MASK_A; // see RL1 see RL13 see RL15
  assign wmask_b = psrc_pkg::IMPL_MASK_B & CAPABILITY_MASK_B; // see RL2 see RL13 see RL15

  always_comb begin
    nxt_soft_reset_a = soft_reset_a_ff;
    nxt_soft_reset_b = soft_reset_b_ff;
    if (acc && PWRITE && hit_a) begin
      nxt_soft_reset_a = (soft_reset_a_ff & ~wmask_a) | (PWDATA & wmask_a); // see RL1
    end
    if (acc && PWRITE && hit_b) begin
      nxt_soft_reset_b = (soft_reset_b_ff & ~wmask_b) | (PWDATA & wmask_b); // see RL2
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      soft_reset_a_ff <= psrc_pkg::RST_SOFT_RESET; // see RL3
    end else begin
      soft_reset_a_ff <= nxt_soft_reset_a;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      soft_reset_b_ff <= psrc_pkg::RST_SOFT_RESET; // see RL3
    end else begin
      soft_reset_b_ff <= nxt_soft_reset_b;
    end
  end

  // -----------------------------------------------------------------------
  // Read path
  // -----------------------------------------------------------------------
  // Read data is registered so it comes from a flip-flop; it is loaded in
  // the setup cycle and stands through the access phase.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      if (hit_a) begin
        PRDATA <= soft_reset_a_ff; // see RL13
      end else if (hit_b) begin
        PRDATA <= soft_reset_b_ff; // see RL13
      end else begin
        PRDATA <= 32'h0000_0000;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Peripheral reset outputs
  // -----------------------------------------------------------------------
  // A set bit holds its unit in reset until software clears it.
  assign CAN_CTRL_ZERO_RESET     = soft_reset_a_ff[psrc_pkg::BIT_CAN_ZERO];  // see RL4 see RL14
  assign CONV_ZERO_RESET         = soft_reset_a_ff[psrc_pkg::BIT_CONV_ZERO]; // see RL5 see RL14
  assign HIBERNATION_UNIT_RESET  = soft_reset_a_ff[psrc_pkg::BIT_HIBERNATE]; // see RL6 see RL14
  assign WATCHDOG_UNIT_RESET     = soft_reset_a_ff[psrc_pkg::BIT_WDOG];      // see RL7 see RL14
  assign COMPARATOR_TWO_RESET    = soft_reset_b_ff[psrc_pkg::BIT_CMP_TWO];   // see RL8
  assign COMPARATOR_ONE_RESET    = soft_reset_b_ff[psrc_pkg::BIT_CMP_ONE];   // see RL8
  assign COMPARATOR_ZERO_RESET   = soft_reset_b_ff[psrc_pkg::BIT_CMP_ZERO];  // see RL8
  assign GP_TIMER_THREE_RESET    = soft_reset_b_ff[psrc_pkg::BIT_TMR_THREE]; // see RL9
  assign GP_TIMER_TWO_RESET      = soft_reset_b_ff[psrc_pkg::BIT_TMR_TWO];   // see RL9
  assign GP_TIMER_ONE_RESET      = soft_reset_b_ff[psrc_pkg::BIT_TMR_ONE];   // see RL9
  assign GP_TIMER_ZERO_RESET     = soft_reset_b_ff[psrc_pkg::BIT_TMR_ZERO];  // see RL9
  assign TWO_WIRE_BUS_ZERO_RESET = soft_reset_b_ff[psrc_pkg::BIT_TWI_ZERO];  // see RL10
  assign SYNC_SERIAL_ZERO_RESET  = soft_reset_b_ff[psrc_pkg::BIT_SSP_ZERO];  // see RL11
  assign ASYNC_SERIAL_ONE_RESET  = soft_reset_b_ff[psrc_pkg::BIT_ASY_ONE];   // see RL12
  assign ASYNC_SERIAL_ZERO_RESET = soft_reset_b_ff[psrc_pkg::BIT_ASY_ZERO];  // see RL12

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  property p_write_a_masked;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (acc && PWRITE && hit_a) |=>
        ((soft_reset_a_ff ^ $past(soft_reset_a_ff)) & ~$past(wmask_a)) == 32'h0000_0000;
  endproperty
  a_write_a_masked: assert property (p_write_a_masked) // see RL1
    else $error("Register A changed a bit outside the capability mask.");

  property p_write_b_masked;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (acc && PWRITE && hit_b) |=>
        (soft_reset_b_ff & $past(wmask_b)) == ($past(PWDATA) & $past(wmask_b));
  endproperty
  a_write_b_masked: assert property (p_write_b_masked) // see RL2
    else $error("Register B did not take the masked write data.");

  property p_write_a_takes;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (acc && PWRITE && hit_a) |=>
        (soft_reset_a_ff & $past(wmask_a)) == ($past(PWDATA) & $past(wmask_a));
  endproperty
  a_write_a_takes: assert property (p_write_a_takes) // see RL1
    else $error("Register A did not take the masked write data.");

  property p_reserved_zero;
    @(posedge SYS_CLK) disable iff (!RST_N)
      ((soft_reset_a_ff & ~psrc_pkg::IMPL_MASK_A) == 32'h0000_0000) &&
      ((soft_reset_b_ff & ~psrc_pkg::IMPL_MASK_B) == 32'h0000_0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // see RL13
    else $error("A reserved bit became nonzero.");

  property p_no_spurious_change;
    @(posedge SYS_CLK) disable iff (!RST_N)
      !(acc && PWRITE) |=> $stable(soft_reset_a_ff) && $stable(soft_reset_b_ff);
  endproperty
  a_no_spurious_change: assert property (p_no_spurious_change) // see RL15
    else $error("A reset register changed without a write.");

  property p_read_b;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (PSEL && !PENABLE && !PWRITE && hit_b) |=> (PRDATA == $past(soft_reset_b_ff));
  endproperty
  a_read_b: assert property (p_read_b) // see RL13
    else $error("Read data does not match register B.");

  property p_hib_out;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (acc && PWRITE && hit_a && PWDATA[psrc_pkg::BIT_HIBERNATE] &&
       wmask_a[psrc_pkg::BIT_HIBERNATE])
        |=> HIBERNATION_UNIT_RESET;
  endproperty
  a_hib_out: assert property (p_hib_out) // see RL6
    else $error("Hibernation reset did not follow the written bit.");

  property p_timer_out;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (acc && PWRITE && hit_b && wmask_b[psrc_pkg::BIT_TMR_THREE] &&
       !PWDATA[psrc_pkg::BIT_TMR_THREE]) |=> !GP_TIMER_THREE_RESET;
  endproperty
  a_timer_out: assert property (p_timer_out) // see RL14
    else $error("Timer three reset not released after a clearing write.");

  property p_reset_zero;
    @(posedge SYS_CLK) $rose(RST_N) |-> (soft_reset_a_ff == psrc_pkg::RST_SOFT_RESET) &&
      (soft_reset_b_ff == psrc_pkg::RST_SOFT_RESET);
  endproperty
  a_reset_zero: assert property (p_reset_zero) // see RL3
    else $error("Registers not zero after reset.");

  // A present unit's reset pin follows the bit last written to it.
  // Multi-bit fields are checked only when every unit of the field is present.
  property p_can_out;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (acc && PWRITE && hit_a && wmask_a[psrc_pkg::BIT_CAN_ZERO])
        |=> (CAN_CTRL_ZERO_RESET == $past(PWDATA[psrc_pkg::BIT_CAN_ZERO]));
  endproperty
  a_can_out: assert property (p_can_out) // see RL4
    else $error("CAN reset output did not follow the written bit.");

  property p_conv_out;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (acc && PWRITE && hit_a && wmask_a[psrc_pkg::BIT_CONV_ZERO])
        |=> (CONV_ZERO_RESET == $past(PWDATA[psrc_pkg::BIT_CONV_ZERO]));
  endproperty
  a_conv_out: assert property (p_conv_out) // see RL5
    else $error("Converter reset output did not follow the written bit.");

  property p_wdog_out;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (acc && PWRITE && hit_a && wmask_a[psrc_pkg::BIT_WDOG])
        |=> (WATCHDOG_UNIT_RESET == $past(PWDATA[psrc_pkg::BIT_WDOG]));
  endproperty
  a_wdog_out: assert property (p_wdog_out) // see RL7
    else $error("Watchdog reset output did not follow the written bit.");

  property p_cmp_out;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (acc && PWRITE && hit_b &&
       (wmask_b[psrc_pkg::BIT_CMP_TWO:psrc_pkg::BIT_CMP_ZERO] == 3'h7))
        |=> ({COMPARATOR_TWO_RESET, COMPARATOR_ONE_RESET, COMPARATOR_ZERO_RESET} ==
             $past(PWDATA[psrc_pkg::BIT_CMP_TWO:psrc_pkg::BIT_CMP_ZERO]));
  endproperty
  a_cmp_out: assert property (p_cmp_out) // see RL8
    else $error("Comparator reset outputs did not follow the written bits.");

  property p_tmr_out;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (acc && PWRITE && hit_b &&
       (wmask_b[psrc_pkg::BIT_TMR_THREE:psrc_pkg::BIT_TMR_ZERO] == 4'hf))
        |=> ({GP_TIMER_THREE_RESET, GP_TIMER_TWO_RESET,
              GP_TIMER_ONE_RESET, GP_TIMER_ZERO_RESET} ==
             $past(PWDATA[psrc_pkg::BIT_TMR_THREE:psrc_pkg::BIT_TMR_ZERO]));
  endproperty
  a_tmr_out: assert property (p_tmr_out) // see RL9
    else $error("Timer reset outputs did not follow the written bits.");

  property p_twi_out;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (acc && PWRITE && hit_b && wmask_b[psrc_pkg::BIT_TWI_ZERO])
        |=> (TWO_WIRE_BUS_ZERO_RESET == $past(PWDATA[psrc_pkg::BIT_TWI_ZERO]));
  endproperty
  a_twi_out: assert property (p_twi_out) // see RL10
    else $error("Two-wire bus reset output did not follow the written bit.");

  property p_ssp_out;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (acc && PWRITE && hit_b && wmask_b[psrc_pkg::BIT_SSP_ZERO])
        |=> (SYNC_SERIAL_ZERO_RESET == $past(PWDATA[psrc_pkg::BIT_SSP_ZERO]));
  endproperty
  a_ssp_out: assert property (p_ssp_out) // see RL11
    else $error("Sync serial reset output did not follow the written bit.");

  property p_asy_out;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (acc && PWRITE && hit_b &&
       (wmask_b[psrc_pkg::BIT_ASY_ONE:psrc_pkg::BIT_ASY_ZERO] == 2'h3))
        |=> ({ASYNC_SERIAL_ONE_RESET, ASYNC_SERIAL_ZERO_RESET} ==
             $past(PWDATA[psrc_pkg::BIT_ASY_ONE:psrc_pkg::BIT_ASY_ZERO]));
  endproperty
  a_asy_out: assert property (p_asy_out) // see RL12
    else $error("Async serial reset outputs did not follow the written bits.");

  property p_write_b_hold;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (acc && PWRITE && hit_b) |=>
        ((soft_reset_b_ff ^ $past(soft_reset_b_ff)) & ~$past(wmask_b)) == 32'h0000_0000;
  endproperty
  a_write_b_hold: assert property (p_write_b_hold) // see RL2
    else $error("Register B changed a bit outside the capability mask.");

  property p_absent_hold;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (acc && PWRITE) |=>
        (((soft_reset_a_ff ^ $past(soft_reset_a_ff)) & ~$past(CAPABILITY_MASK_A)) == 32'h0) &&
        (((soft_reset_b_ff ^ $past(soft_reset_b_ff)) & ~$past(CAPABILITY_MASK_B)) == 32'h0);
  endproperty
  a_absent_hold: assert property (p_absent_hold) // see RL15
    else $error("A bit of an absent unit changed on a write.");

  property p_read_a;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (PSEL && !PENABLE && !PWRITE && hit_a) |=> (PRDATA == $past(soft_reset_a_ff));
  endproperty
  a_read_a: assert property (p_read_a) // see RL13
    else $error("Read data does not match register A.");

  property p_unmapped_read;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (PSEL && !PENABLE && !PWRITE && !hit_a && !hit_b)
        |=> (PRDATA == 32'h0000_0000);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) // see RL13
    else $error("Read of an unmapped address returned nonzero data.");

endmodule // psrc_top

// [rtl/psrc_pkg.sv]
/*
  Package for the peripheral soft reset controller: register offsets, field
  positions, writable-bit masks and reset values.
  Assumes a 32-bit APB slave with byte addresses and one word per register.
*/
package psrc_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [11:0] OFS_SOFT_RESET_A = 12'h040;
  localparam logic [11:0] OFS_SOFT_RESET_B = 12'h044;
  localparam logic [31:0] RST_SOFT_RESET   = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // Field positions, register A
  // ---------------------------------------------------------------------
  localparam int BIT_CAN_ZERO  = 24;
  localparam int BIT_CONV_ZERO = 16;
  localparam int BIT_HIBERNATE = 6;
  localparam int BIT_WDOG      = 3;

  // ---------------------------------------------------------------------
  // Field positions, register B
  // ---------------------------------------------------------------------
  localparam int BIT_CMP_TWO   = 26;
  localparam int BIT_CMP_ONE   = 25;
  localparam int BIT_CMP_ZERO  = 24;
  localparam int BIT_TMR_THREE = 19;
  localparam int BIT_TMR_TWO   = 18;
  localparam int BIT_TMR_ONE   = 17;
  localparam int BIT_TMR_ZERO  = 16;
  localparam int BIT_TWI_ZERO  = 12;
  localparam int BIT_SSP_ZERO  = 4;
  localparam int BIT_ASY_ONE   = 1;
  localparam int BIT_ASY_ZERO  = 0;

  // Implemented (read/write) bits; every other bit reads as zero.
  localparam logic [31:0] IMPL_MASK_A = 32'h0101_0048;
  localparam logic [31:0] IMPL_MASK_B = 32'h070f_1013;

endpackage : psrc_pkg

// [verif/psrc_top_tb.sv]
/*
  Self-checking testbench for the peripheral soft reset controller.
  Assumes a zero-wait APB slave on SYS_CLK and an async active-low reset.
*/
`timescale 1ns/1ps

module psrc_top_tb;

  logic        sys_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] cap_a;
  logic [31:0] cap_b;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  wire  [31:0] pin_a;
  wire  [31:0] pin_b;
  int          num_errors;
  int          checks_done;
  logic [31:0] rd;
  logic        err;

  psrc_top psrc_top_i (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr),
    .CAPABILITY_MASK_A(cap_a), .CAPABILITY_MASK_B(cap_b),
    .CAN_CTRL_ZERO_RESET(pin_a[24]), .CONV_ZERO_RESET(pin_a[16]),
    .HIBERNATION_UNIT_RESET(pin_a[6]), .WATCHDOG_UNIT_RESET(pin_a[3]),
    .COMPARATOR_ZERO_RESET(pin_b[24]), .COMPARATOR_ONE_RESET(pin_b[25]),
    .COMPARATOR_TWO_RESET(pin_b[26]), .GP_TIMER_ZERO_RESET(pin_b[16]),
    .GP_TIMER_ONE_RESET(pin_b[17]), .GP_TIMER_TWO_RESET(pin_b[18]),
    .GP_TIMER_THREE_RESET(pin_b[19]), .TWO_WIRE_BUS_ZERO_RESET(pin_b[12]),
    .SYNC_SERIAL_ZERO_RESET(pin_b[4]), .ASYNC_SERIAL_ZERO_RESET(pin_b[0]),
    .ASYNC_SERIAL_ONE_RESET(pin_b[1])
  );

  // Positions without a reset pin are tied low so every compared bit is driven.
  assign pin_a[31:25] = 7'h00;
  assign pin_a[23:17] = 7'h00;
  assign pin_a[15:7]  = 9'h000;
  assign pin_a[5:4]   = 2'h0;
  assign pin_a[2:0]   = 3'h0;
  assign pin_b[31:27] = 5'h00;
  assign pin_b[23:20] = 4'h0;
  assign pin_b[15:13] = 3'h0;
  assign pin_b[11:5]  = 7'h00;
  assign pin_b[3:2]   = 2'h0;

  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------------
  // Reporting and bus tasks
  // ---------------------------------------------------------------------
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // The request is held until PREADY is seen high, for at most 20 cycles; a longer wait is reported as a failure.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      num_errors++;
      $display("[FAIL] %0t bus transfer never completed", $time);
      final_report();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  // One scenario: set capabilities, write both registers, read back, check pins.
  task automatic scenario(input logic [31:0] ca, input logic [31:0] cb,
                          input logic [31:0] wa, input logic [31:0] wb,
                          input logic [31:0] ea, input logic [31:0] eb);
    @(posedge sys_clk);
    cap_a <= ca;
    cap_b <= cb;
    apb(1'h1, psrc_pkg::OFS_SOFT_RESET_A, wa);
    apb(1'h1, psrc_pkg::OFS_SOFT_RESET_B, wb);
    apb(1'h0, psrc_pkg::OFS_SOFT_RESET_A, 32'h0);
    check(rd, ea, "reg a readback");
    check({31'h0, err}, 32'h0, "error on mapped read");
    apb(1'h0, psrc_pkg::OFS_SOFT_RESET_B, 32'h0);
    check(rd, eb, "reg b readback");
    check(pin_a & psrc_pkg::IMPL_MASK_A, ea, "pins a");
    check(pin_b & psrc_pkg::IMPL_MASK_B, eb, "pins b");
  endtask

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    num_errors  = 0;
    checks_done = 0;
    rst_n   = 1'h0;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 12'h0;
    pwdata  = 32'h0;
    cap_a   = 32'hffffffff;
    cap_b   = 32'hffffffff;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'h1;
    check(pin_a & psrc_pkg::IMPL_MASK_A, 32'h0, "pins a after reset");
    check(pin_b & psrc_pkg::IMPL_MASK_B, 32'h0, "pins b after reset");
    apb(1'h0, psrc_pkg::OFS_SOFT_RESET_A, 32'h0);
    check(rd, 32'h0, "reg a reset value");
    apb(1'h0, psrc_pkg::OFS_SOFT_RESET_B, 32'h0);
    check(rd, 32'h0, "reg b reset value");
    // Arguments: cap A, cap B, write A, write B, expected A, expected B.
    scenario(32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
             32'h0101_0048, 32'h070f_1013);
    scenario(32'hffff_ffff, 32'hffff_ffff, 32'h0000_0000, 32'h0000_0000,
             32'h0000_0000, 32'h0000_0000);
    scenario(32'h0000_0008, 32'h0001_0001, 32'hffff_ffff, 32'hffff_ffff,
             32'h0000_0008, 32'h0001_0001);
    scenario(32'hffff_ffff, 32'hffff_ffff, 32'h0100_0040, 32'h0408_1002,
             32'h0100_0040, 32'h0408_1002);
    scenario(32'hffff_ffff, 32'hffff_ffff, 32'h0001_0008, 32'h0307_0011,
             32'h0001_0008, 32'h0307_0011);
    scenario(32'h0000_0000, 32'h0000_0000, 32'hffff_ffff, 32'h0000_0000,
             32'h0001_0008, 32'h0307_0011);
    apb(1'h1, 12'h048, 32'hffffffff);
    check({31'h0, err}, 32'h1, "error on unmapped write");
    apb(1'h0, 12'h048, 32'h0);
    check(rd, 32'h0, "unmapped read data");
    apb(1'h0, psrc_pkg::OFS_SOFT_RESET_A, 32'h0);
    check(rd, 32'h00010008, "reg a after unmapped write");
    @(posedge sys_clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    check(pin_a & psrc_pkg::IMPL_MASK_A, 32'h0, "pins a in reset");
    check(pin_b & psrc_pkg::IMPL_MASK_B, 32'h0, "pins b in reset");
    rst_n <= 1'h1;
    apb(1'h0, psrc_pkg::OFS_SOFT_RESET_B, 32'h0);
    check(rd, 32'h0, "reg b after second reset");
    final_report();
  end

endmodule // psrc_top_tb
